// ---- verilog/ppp_defines.svh ----
// constants for the prom programming port, both ends
// assumes inclusion by bare name from design files
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH
`define PPP_ADDR_W        15
`define PPP_DATA_W        8
`define PPP_PROG_LO       15'h4000
`define PPP_PROG_HI       15'h7FFF
`define PPP_FILL_HI       15'h3FFF
`define PPP_FILL_BYTE     8'hFF
`define PPP_ERASED_BYTE   8'hFF
`define PPP_WR_TIME_NS    100
`define PPP_CLK_NS        10
`define PPP_WR_CYC        ((`PPP_WR_TIME_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_RD_CYC        2
`endif

// ---- verilog/ppp_pkg.sv ----
// types shared by both ends of the prom programming port
// assumes nothing beyond a systemverilog compiler
package ppp_pkg;
    typedef enum logic [4:0] {
        PPP_IDLE   = 5'b00001,
        PPP_SETUP  = 5'b00010,
        PPP_STROBE = 5'b00100,
        PPP_VERIFY = 5'b01000,
        PPP_DONE   = 5'b10000
    } ppp_host_st_e;
endpackage

// ---- verilog/ppp_if.sv ----
// pin-level link between the memory device and its programmer
// the bench resolves the data bus from the two enables
`timescale 1ns/1ps
interface ppp_if;
    logic       reset_n;
    logic [6:0] port_one_upper_seven_bits;
    logic       port_one_bit_zero;
    logic [3:0] input_port_two_low_nibble;
    logic [3:0] input_port_two_high_nibble;
    logic       port_three_bit_zero;
    logic       port_three_bit_one;
    logic       port_three_bit_two;
    logic       port_three_bit_three;
    logic       port_four_bit_zero;
    logic       port_four_bit_one;
    logic       port_four_bit_two;
    logic       port_four_bit_three;
    logic [3:0] open_drain_port_five;
    logic       chip_sel_n;
    logic [7:0] dev_data_o;
    logic [7:0] dev_data_oe_n;
    logic [7:0] host_data_o;
    logic [7:0] host_data_oe_n;
    logic [7:0] data_bus;
    modport dev (
        input  reset_n, port_one_upper_seven_bits, port_one_bit_zero,
        input  input_port_two_low_nibble, input_port_two_high_nibble,
        input  port_three_bit_zero, port_three_bit_one, port_three_bit_two,
        input  port_three_bit_three, port_four_bit_zero, port_four_bit_one,
        input  port_four_bit_two, port_four_bit_three, open_drain_port_five,
        input  chip_sel_n, data_bus,
        output dev_data_o, dev_data_oe_n
    );
    modport host (
        output reset_n, port_one_upper_seven_bits, port_one_bit_zero,
        output input_port_two_low_nibble, input_port_two_high_nibble,
        output port_three_bit_zero, port_three_bit_one, port_three_bit_two,
        output port_three_bit_three, port_four_bit_zero, port_four_bit_one,
        output port_four_bit_two, port_four_bit_three, open_drain_port_five,
        output chip_sel_n, host_data_o, host_data_oe_n,
        input  data_bus
    );
endinterface

// ---- verilog/ppp_device.sv ----
// device end: program memory reached over the ports while reset is low
// assumes the programmer keeps pins synchronous to i_sys_clk
`timescale 1ns/1ps
`include "ppp_defines.svh"

// Operation
// - reset low enters programming mode
// - port one bits 1-7 give A4-A10
// - port two low nibble gives A0-A3
// - port three bits 0,1 A11,A12; bit2 oe
// - programmer applies vpp on port three bit3
// - port four bits 0,1 give A13,A14
// - port zero is the data bus
// - reference pin acts as chip select
// - programmer leaves port five open; ppp_host holds it at 4'h0
// - clock stays attached while programming
// - cs and oe low read addressed byte
// - cs and oe high float data bus
// - program: oe high, vpp, address, data
// - cs low under program conditions writes
// - programmer writes only 4000-7FFF; ppp_host also accepts 0000-3FFF when the data is FF
// - full-range writes fill 0000-3FFF with FF; ppp_host does no fill itself, each FF byte there is one separate write
module ppp_device
    import ppp_pkg::*;
#(
    parameter int DEPTH = 1 << `PPP_ADDR_W
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    ppp_if.dev              pins,
    output logic            o_prog_mode,
    output logic            o_write_busy
);
    logic [`PPP_DATA_W-1:0] mem_reg [DEPTH];
    logic [`PPP_ADDR_W-1:0] addr;
    logic                   cs_n;
    logic                   oe_n;
    logic                   vpp;
    logic                   prog_mode;
    logic                   cs_n_reg;
    logic                   busy_reg;
    logic [7:0]             busy_cnt_reg;
    logic [`PPP_DATA_W-1:0] rd_data_reg;
    logic                   drive;
    logic                   wr_take;

    assign prog_mode = !pins.reset_n;
    assign addr = {pins.port_four_bit_one, pins.port_four_bit_zero,
                   pins.port_three_bit_one, pins.port_three_bit_zero,
                   pins.port_one_upper_seven_bits,
                   pins.input_port_two_low_nibble};
    assign cs_n = pins.chip_sel_n;
    assign oe_n = pins.port_three_bit_two;
    assign vpp  = pins.port_three_bit_three;
    // one decode shared by the cell write and the busy timer
    assign wr_take = prog_mode && vpp && oe_n && !cs_n && cs_n_reg && !busy_reg;

    // the cell is only programmed on the falling edge of cs, so a held
    // low cs writes once, not every cycle
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_n_reg <= 1'b1;
        end else begin
            cs_n_reg <= cs_n;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (wr_take) begin
            mem_reg[addr] <= pins.data_bus;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_reg     <= 1'b0;
            busy_cnt_reg <= 8'h00;
        end else if (wr_take) begin
            busy_reg     <= 1'b1;
            busy_cnt_reg <= 8'(`PPP_WR_CYC - 1);
        end else if (busy_reg) begin
            if (busy_cnt_reg == 8'h00) begin
                busy_reg <= 1'b0;
            end else begin
                busy_cnt_reg <= busy_cnt_reg - 8'h01;
            end
        end
    end

    // read path: verify (cs high, oe low, vpp) also returns data
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= mem_reg[addr];
        end
    end

    assign drive = prog_mode && !oe_n && (!cs_n || vpp);
    assign pins.dev_data_o    = rd_data_reg;
    assign pins.dev_data_oe_n = {`PPP_DATA_W{!drive}};
    assign o_prog_mode  = prog_mode;
    assign o_write_busy = busy_reg;
endmodule

// ---- verilog/ppp_host.sv ----
// programmer end: writes one byte and verifies it by readback
// assumes a user pulse i_start with address and data held stable
`timescale 1ns/1ps
`include "ppp_defines.svh"
module ppp_host
    import ppp_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_start,
    input  wire logic [`PPP_ADDR_W-1:0] i_addr,
    input  wire logic [`PPP_DATA_W-1:0] i_data,
    ppp_if.host                         pins,
    output logic                        o_busy,
    output logic                        o_done,
    output logic                        o_ok,
    output logic                        o_range_err
);
    ppp_host_st_e           st_reg;
    logic [`PPP_ADDR_W-1:0] addr_reg;
    logic [`PPP_DATA_W-1:0] data_reg;
    logic [7:0]             cnt_reg;
    logic                   ok_reg;
    logic                   err_reg;
    logic                   in_range;

    // low half only takes the erased fill value
    assign in_range = (i_addr >= `PPP_PROG_LO) ||
                      (i_addr <= `PPP_FILL_HI && i_data == `PPP_FILL_BYTE);

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg   <= PPP_IDLE;
            addr_reg <= '0;
            data_reg <= '0;
            cnt_reg  <= 8'h00;
            ok_reg   <= 1'b0;
            err_reg  <= 1'b0;
        end else begin
            unique case (st_reg)
                PPP_IDLE: begin
                    if (i_start) begin
                        err_reg <= !in_range;
                        if (in_range) begin
                            addr_reg <= i_addr;
                            data_reg <= i_data;
                            st_reg   <= PPP_SETUP;
                        end
                    end
                end
                PPP_SETUP: begin
                    st_reg  <= PPP_STROBE;
                    cnt_reg <= 8'(`PPP_WR_CYC + 1);
                end
                PPP_STROBE: begin
                    if (cnt_reg == 8'h00) begin
                        st_reg  <= PPP_VERIFY;
                        cnt_reg <= 8'(`PPP_RD_CYC);
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                PPP_VERIFY: begin
                    if (cnt_reg == 8'h00) begin
                        ok_reg <= (pins.data_bus == data_reg);
                        st_reg <= PPP_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                PPP_DONE: begin
                    st_reg <= PPP_IDLE;
                end
            endcase
        end
    end

    // the device stays out of programming mode while the programmer itself is in reset
    assign pins.reset_n = i_rst;
    assign pins.input_port_two_low_nibble = addr_reg[3:0];
    assign pins.port_one_upper_seven_bits = addr_reg[10:4];
    assign pins.port_three_bit_zero = addr_reg[11];
    assign pins.port_three_bit_one  = addr_reg[12];
    assign pins.port_four_bit_zero  = addr_reg[13];
    assign pins.port_four_bit_one   = addr_reg[14];
    // unused pins are modelled as held low; the bench treats them as open
    assign pins.port_one_bit_zero          = 1'b0;
    assign pins.input_port_two_high_nibble = 4'h0;
    assign pins.port_four_bit_two          = 1'b0;
    assign pins.port_four_bit_three        = 1'b0;
    assign pins.open_drain_port_five       = 4'h0;
    // done doubles as one plain read-out cycle, so the normal read path is used too
    assign pins.port_three_bit_three = !(st_reg == PPP_IDLE || st_reg == PPP_DONE);
    assign pins.port_three_bit_two   = !(st_reg == PPP_VERIFY || st_reg == PPP_DONE);
    assign pins.chip_sel_n  = !((st_reg == PPP_STROBE && cnt_reg != 8'h00) ||
                                st_reg == PPP_DONE);
    assign pins.host_data_o = data_reg;
    assign pins.host_data_oe_n = {`PPP_DATA_W{!(st_reg == PPP_SETUP ||
                                                st_reg == PPP_STROBE)}};
    assign o_busy      = (st_reg != PPP_IDLE);
    assign o_done      = (st_reg == PPP_DONE);
    assign o_ok        = ok_reg;
    assign o_range_err = err_reg;
endmodule

// ---- test/ppp_checker.sv ----
// assertions on the pins between the memory device and its programmer
// assumes plain interface signals in one clock domain, reset async high
`timescale 1ns/1ps
module ppp_checker (
    input wire logic       i_sys_clk,
    input wire logic       i_rst,
    input wire logic       reset_n,
    input wire logic       port_three_bit_two,
    input wire logic       port_three_bit_three,
    input wire logic       chip_sel_n,
    input wire logic [7:0] dev_data_oe_n,
    input wire logic [7:0] host_data_o,
    input wire logic [7:0] host_data_oe_n
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // verify state seen twice, so the device has had its one cycle to answer
    sequence verify_held;
        (port_three_bit_three && !port_three_bit_two && chip_sel_n)[*2];
    endsequence
    sequence strobe_fall;
        $fell(chip_sel_n) && port_three_bit_three;
    endsequence
    sequence read_sel;
        !chip_sel_n && !port_three_bit_two && !port_three_bit_three;
    endsequence
    a_mode_held_low: assert property (!reset_n)
        else $error("programmer left programming mode");
    a_bus_floats: assert property (chip_sel_n && port_three_bit_two |-> dev_data_oe_n == 8'hFF)
        else $error("device drives bus while deselected");
    a_verify_drives: assert property (verify_held |-> dev_data_oe_n == 8'h00)
        else $error("device silent in verify");
    a_no_contention: assert property ((dev_data_oe_n | host_data_oe_n) == 8'hFF)
        else $error("both ends drive the data bus");
    a_prog_conditions: assert property ($fell(chip_sel_n) |->
        (port_three_bit_three && port_three_bit_two && host_data_oe_n == 8'h00)
        || (!port_three_bit_three && !port_three_bit_two))
        else $error("strobe without program conditions");
    a_read_drives: assert property (read_sel |-> dev_data_oe_n == 8'h00)
        else $error("device silent in read-out");
    a_strobe_length: assert property (strobe_fall |-> ##10 !chip_sel_n ##1 chip_sel_n)
        else $error("write strobe length wrong");
    a_verify_follows: assert property ($rose(chip_sel_n) && port_three_bit_three |->
        ##[1:2] !port_three_bit_two)
        else $error("no readback after write");
    a_data_held: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(host_data_o))
        else $error("write data moved during strobe");
endmodule

// ---- test/tb_top.sv ----
// self-checking bench: programmer end drives device end over ppp_if
// assumes both ends share i_sys_clk; bench resolves the data bus
`timescale 1ns/1ps
module tb_top;
    logic        i_sys_clk = 0;
    logic        i_rst = 1;
    logic        start = 0;
    logic [14:0] addr = 0;
    logic [7:0]  data = 0;
    logic [7:0]  flt = 8'h5A;
    logic        o_prog_mode, o_write_busy, o_busy, o_done, o_ok, o_range_err;
    logic [14:0] pa;
    logic [7:0]  mem [int];
    int          n_fail = 0, tests_run = 0, cyc = 0, vcnt = 0, wb = 0, seed = 32'h364801E0;
    ppp_if pif ();
    always #5 i_sys_clk = ~i_sys_clk;
    // released lines show a pattern that flips every cycle
    assign pif.data_bus = (~pif.dev_data_oe_n & pif.dev_data_o) | (~pif.host_data_oe_n
        & pif.host_data_o) | (pif.dev_data_oe_n & pif.host_data_oe_n & flt);
    assign pa = {pif.port_four_bit_one, pif.port_four_bit_zero, pif.port_three_bit_one,
        pif.port_three_bit_zero, pif.port_one_upper_seven_bits, pif.input_port_two_low_nibble};
    wire vc = pif.port_three_bit_three && !pif.port_three_bit_two && pif.chip_sel_n;
    wire rd = !pif.port_three_bit_three && !pif.port_three_bit_two && !pif.chip_sel_n;
    ppp_device ppp_device_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .pins(pif),
        .o_prog_mode(o_prog_mode), .o_write_busy(o_write_busy));
    ppp_host ppp_host_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_start(start), .i_addr(addr),
        .i_data(data), .pins(pif), .o_busy(o_busy), .o_done(o_done), .o_ok(o_ok),
        .o_range_err(o_range_err));
    ppp_checker ppp_checker_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .reset_n(pif.reset_n),
        .port_three_bit_two(pif.port_three_bit_two),
        .port_three_bit_three(pif.port_three_bit_three), .chip_sel_n(pif.chip_sel_n),
        .dev_data_oe_n(pif.dev_data_oe_n), .host_data_o(pif.host_data_o),
        .host_data_oe_n(pif.host_data_oe_n));
    task automatic chk(input bit c, input string m);
        tests_run++;
        if (!c) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        flt <= ~flt;
        cyc <= cyc + 1;
        wb <= wb + int'(o_write_busy === 1'b1);
        vcnt <= vc ? vcnt + 1 : 0;
        if (vc && vcnt >= 2 && mem.exists(pa)) chk(pif.data_bus === mem[pa], "readback");
        if (rd && mem.exists(pa)) chk(pif.data_bus === mem[pa], "read-out");
        if (cyc == 3000) begin
            n_fail++;
            conclude();
        end
    end
    // one program-and-verify with a stray start pulsed mid-operation that must be ignored; a low-half byte other than FF only checks the refusal
    task automatic run(input logic [14:0] a, input logic [7:0] d);
        bit bad;
        int i;
        int w0;
        bad = a < 15'h4000 && d != 8'hFF;
        @(posedge i_sys_clk) #1;
        addr = a;
        data = d;
        start = 1;
        w0 = wb;
        if (!bad) mem[a] = d;
        @(posedge i_sys_clk) #1 start = 0;
        repeat (2) @(posedge i_sys_clk);
        #1;
        if (bad) begin
            chk(o_range_err === 1'b1 && o_busy === 1'b0, "refused start");
            return;
        end
        addr = ~a;
        start = 1;
        @(posedge i_sys_clk) #1 start = 0;
        i = 0;
        while (o_done !== 1'b1 && i < 40) begin
            @(posedge i_sys_clk) #1;
            i++;
        end
        chk(o_done === 1'b1 && o_ok === 1'b1 && wb - w0 == 10 && o_range_err === 1'b0,
            "program");
        @(posedge i_sys_clk) #1;
        chk(o_done === 1'b0 && o_busy === 1'b0, "single pulse");
    endtask
    initial begin
        repeat (12) @(posedge i_sys_clk);
        chk(o_prog_mode === 1'b0, "mode in reset");
        #1 i_rst = 0;
        @(posedge i_sys_clk) #1;
        chk(o_prog_mode === 1'b1, "mode");
        run(15'h4000, 8'h00);
        run(15'h7FFF, 8'hA5);
        run(15'h3FFF, 8'hFF);
        run(15'h0000, 8'hFF);
        run(15'h0100, 8'h5A);
        repeat (20) run(15'h4000 | 15'($random(seed)), 8'($random(seed)));
        conclude();
    end
endmodule
